/* File: src/poll_seq_regs.vh */
// constants for the poll sequencer: status codes, field values, timing
`ifndef POLL_SEQ_REGS_VH
`define POLL_SEQ_REGS_VH
// register offsets (word-wide plain port)
`define REG_CTRL        4'h0
`define REG_WAIT        4'h1
`define REG_STATUS      4'h2
`define REG_COUNT       4'h3
// control register fields
`define CTRL_BEACON_BIT 0
`define CTRL_OWN_BIT    1
`define WAIT_RESET      32'h000003E8
// addressing modes
`define MODE_SHORT      2'h2
`define MODE_EXT        2'h3
// confirm status codes
`define ST_SUCCESS      4'h0
`define ST_CHAN_FAIL    4'h1
`define ST_NO_ACK       4'h2
`define ST_NO_DATA      4'h3
`define ST_COUNTER_ERR  4'h4
`define ST_TOO_LONG     4'h5
`define ST_NO_KEY       4'h6
`define ST_UNSUP_SEC    4'h7
`define ST_INVALID      4'h8
// security processing error codes on the engine port
`define SEC_OK          2'h0
`define SEC_COUNTER     2'h1
`define SEC_TOO_LONG    2'h2
`define SEC_NO_KEY      2'h3
`define SEC_LVL_MAX     3'h7
`define KEY_MODE_MAX    2'h3
`define VPAN_MAX        16'hFFFE
`endif

/* File: src/mac_poll_sequencer.v */
// mac poll sequencer: poll request to single confirm plus data indication
// How it works
// - accepted poll sends data request command
// - own coordinator target omits destination fields
// - other targets carry coordinator vpan and address
// - nonzero security level sets security bit
// - security error drops frame, confirms error
// - access failure confirms channel access failure
// - missing ack confirms no ack
// - pending ack turns receiver on
// - non-pending ack confirms no data at once
// - empty or command frame confirms no data
// - nonempty data frame confirms success, indicates data
// - frame wait timeout confirms no data
// - bad parameter confirms invalid parameter
// - confirm carries exactly one allowed status
// - one confirm per request
// - confirm precedes data indication
// - address mode 2 short, 3 extended
// - security level zero through seven
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
`include "poll_seq_regs.vh"
module mac_poll_sequencer (
    input  wire        core_clk,        // mac clock, 200 MHz
    input  wire        arst_n,          // async reset, active low
    // poll request from higher layer
    input  wire        poll_req,        // request pulse
    output wire        poll_ready,      // request may be taken
    input  wire [1:0]  coord_mode,      // coordinator address mode
    input  wire [15:0] coord_vpan,      // coordinator vpan id
    input  wire [63:0] coord_addr,      // coordinator address
    input  wire [2:0]  sec_level,       // security level
    input  wire [1:0]  key_mode,        // key id mode
    input  wire [7:0]  key_index,       // key index
    // confirm and indication
    output reg         poll_cfm,        // confirm pulse
    output reg  [3:0]  poll_status,     // confirm status
    output reg         data_ind,        // data indication pulse
    output reg  [6:0]  data_len,        // indicated payload length
    // security engine
    output reg         sec_start,       // start outgoing processing
    input  wire        sec_done,        // processing finished pulse
    input  wire [1:0]  sec_err,         // processing result
    // transmit side
    output reg         tx_cmd,          // send data request command pulse
    output reg         tx_dst_present,  // destination fields present
    output reg  [15:0] tx_vpan,         // destination vpan
    output reg  [63:0] tx_addr,         // destination address
    output reg  [1:0]  tx_mode,         // destination address mode
    output reg         tx_sec_en,       // security enabled bit
    input  wire        tx_done,         // command sent pulse
    input  wire        tx_chan_fail,    // random access failed pulse
    // ack and receive side
    input  wire        ack_rx,          // ack received pulse
    input  wire        ack_timeout,     // ack wait expired pulse
    input  wire        frame_pending_flag, // pending bit of ack
    output reg         rx_on,           // ask phy to enable receiver
    input  wire        rx_frame,        // frame received pulse
    input  wire        rx_is_cmd,       // frame is mac command
    input  wire [6:0]  rx_len,          // frame payload length
    input  wire        optical_tick,    // one optical clock enable
    input  wire        cap_active,      // inside cap
    // register port
    input  wire [3:0]  reg_addr,        // register index
    input  wire [31:0] reg_wdata,       // write data
    input  wire        reg_wr,          // write strobe
    input  wire        reg_rd,          // read strobe
    output reg  [31:0] reg_rdata        // read data, one cycle later
);
// ----------------------------------------
// states
// ----------------------------------------
localparam [2:0] S_IDLE = 3'd0;
localparam [2:0] S_SEC  = 3'd1;
localparam [2:0] S_TX   = 3'd2;
localparam [2:0] S_ACK  = 3'd3;
localparam [2:0] S_RX   = 3'd4;
localparam [2:0] S_IND  = 3'd5;

// ----------------------------------------
// state and configuration
// ----------------------------------------
reg [2:0]  state_q;
reg [1:0]  ctrl_q;        // bit0 beacon-enabled, bit1 target is own coordinator
reg [31:0] wait_q;        // frame total wait, optical clocks
reg [31:0] wait_cnt_q;
reg [15:0] poll_cnt_q;    // confirms issued
reg [2:0]  tick_s_q;      // optical tick and cap sync chain, tick edge
reg [1:0]  cap_s_q;
reg        tick_d_q;
reg [6:0]  len_q;

// ----------------------------------------
// helpers
// ----------------------------------------
// parameter check used at request time
function params_ok;
    input [1:0]  m;
    input [15:0] v;
    input [2:0]  s;
    input [7:0]  ki;
    input [1:0]  km;
    begin
        params_ok = (m == `MODE_SHORT || m == `MODE_EXT) && (v <= `VPAN_MAX)
                    && (s <= `SEC_LVL_MAX)
                    && (s == 3'h0 || km == 2'h0 || ki != 8'h00);
    end
endfunction

// map security engine error onto confirm status
// only codes from the confirm set come out
function [3:0] sec_status;
    input [1:0] e;
    begin
        case (e)
            `SEC_COUNTER:  sec_status = `ST_COUNTER_ERR;
            `SEC_TOO_LONG: sec_status = `ST_TOO_LONG;
            `SEC_NO_KEY:   sec_status = `ST_NO_KEY;
            default:       sec_status = `ST_UNSUP_SEC;
        endcase
    end
endfunction

// ----------------------------------------
// input sync: tick and cap come from the optical domain
// ----------------------------------------
always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        tick_s_q <= 3'h0;
        cap_s_q  <= 2'h0;
        tick_d_q <= 1'b0;
    end else begin
        tick_s_q <= {tick_s_q[1:0], optical_tick};
        cap_s_q  <= {cap_s_q[0], cap_active};
        // rising edge only: one count per optical clock, whatever its duty cycle
        tick_d_q <= tick_s_q[1] & ~tick_s_q[2];
    end
end

// in beacon mode only optical clocks inside the cap count
wire wait_tick = tick_d_q & (~ctrl_q[`CTRL_BEACON_BIT] | cap_s_q[1]);

// one poll at a time; ready only in idle
assign poll_ready = (state_q == S_IDLE);

// ----------------------------------------
// sequencer
// ----------------------------------------
always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        state_q        <= S_IDLE;
        poll_cfm       <= 1'b0;
        poll_status    <= `ST_SUCCESS;
        data_ind       <= 1'b0;
        data_len       <= 7'h00;
        sec_start      <= 1'b0;
        tx_cmd         <= 1'b0;
        tx_dst_present <= 1'b0;
        tx_vpan        <= 16'h0000;
        tx_addr        <= 64'h0000000000000000;
        tx_mode        <= 2'h0;
        tx_sec_en      <= 1'b0;
        rx_on          <= 1'b0;
        wait_cnt_q     <= 32'h00000000;
        len_q          <= 7'h00;
        poll_cnt_q     <= 16'h0000;
    end else begin
        poll_cfm  <= 1'b0;
        data_ind  <= 1'b0;
        sec_start <= 1'b0;
        tx_cmd    <= 1'b0;
        if (poll_cfm)
            poll_cnt_q <= poll_cnt_q + 16'h0001;
        case (state_q)
            S_IDLE: begin
                // request fields are looked at only in the accepting cycle
                if (poll_req) begin
                    if (!params_ok(coord_mode, coord_vpan, sec_level, key_index, key_mode)) begin
                        poll_cfm    <= 1'b1;
                        poll_status <= `ST_INVALID;
                    end else begin
                        // own coordinator: destination omitted
                        tx_dst_present <= ~ctrl_q[`CTRL_OWN_BIT];
                        tx_vpan        <= ctrl_q[`CTRL_OWN_BIT] ? 16'h0000 : coord_vpan;
                        tx_addr        <= ctrl_q[`CTRL_OWN_BIT] ? 64'h0 : coord_addr;
                        tx_mode        <= ctrl_q[`CTRL_OWN_BIT] ? 2'h0 : coord_mode;
                        tx_sec_en      <= (sec_level != 3'h0);
                        if (sec_level != 3'h0) begin
                            sec_start <= 1'b1;
                            state_q   <= S_SEC;
                        end else begin
                            tx_cmd  <= 1'b1;
                            state_q <= S_TX;
                        end
                    end
                end
            end
            S_SEC: begin
                if (sec_done) begin
                    if (sec_err != `SEC_OK) begin
                        poll_cfm    <= 1'b1; // frame dropped
                        poll_status <= sec_status(sec_err);
                        state_q     <= S_IDLE;
                    end else begin
                        tx_cmd  <= 1'b1;
                        state_q <= S_TX;
                    end
                end
            end
            S_TX: begin
                // a failure report outranks a done report in the same cycle
                if (tx_chan_fail) begin
                    poll_cfm    <= 1'b1;
                    poll_status <= `ST_CHAN_FAIL;
                    state_q     <= S_IDLE;
                end else if (tx_done) begin
                    state_q <= S_ACK;
                end
            end
            S_ACK: begin
                if (ack_rx) begin
                    if (frame_pending_flag) begin
                        rx_on      <= 1'b1;
                        wait_cnt_q <= 32'h00000000;
                        state_q    <= S_RX;
                    end else begin
                        poll_cfm    <= 1'b1;
                        poll_status <= `ST_NO_DATA;
                        state_q     <= S_IDLE;
                    end
                end else if (ack_timeout) begin
                    poll_cfm    <= 1'b1;
                    poll_status <= `ST_NO_ACK;
                    state_q     <= S_IDLE;
                end
            end
            S_RX: begin
                // a frame arriving on the last count still wins over the timeout
                if (rx_frame) begin
                    rx_on    <= 1'b0;
                    poll_cfm <= 1'b1; // confirm first
                    if (rx_is_cmd || rx_len == 7'h00) begin
                        poll_status <= `ST_NO_DATA;
                        state_q     <= S_IDLE;
                    end else begin
                        poll_status <= `ST_SUCCESS;
                        len_q       <= rx_len;
                        state_q     <= S_IND;
                    end
                end else if (wait_cnt_q >= wait_q) begin
                    rx_on       <= 1'b0;
                    poll_cfm    <= 1'b1;
                    poll_status <= `ST_NO_DATA;
                    state_q     <= S_IDLE;
                end else if (wait_tick) begin
                    wait_cnt_q <= wait_cnt_q + 32'h00000001;
                end
            end
            S_IND: begin
                // indication one cycle after the success confirm
                data_ind <= 1'b1;
                data_len <= len_q;
                state_q  <= S_IDLE;
            end
            default: state_q <= S_IDLE;
        endcase
    end
end

// ----------------------------------------
// register port
// ----------------------------------------
// writes are taken while idle too; a wait change mid-poll applies at once
always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        ctrl_q    <= 2'h0;
        wait_q    <= `WAIT_RESET;
        reg_rdata <= 32'h00000000;
    end else begin
        // writes to unmapped offsets are dropped
        if (reg_wr && reg_addr == `REG_CTRL)
            ctrl_q <= reg_wdata[1:0];
        if (reg_wr && reg_addr == `REG_WAIT)
            wait_q <= reg_wdata;
        // status word: bit 8 receiver on, 7:5 state, 4:1 last status, 0 ready
        if (reg_rd) begin
            case (reg_addr)
                `REG_CTRL:   reg_rdata <= {30'h0, ctrl_q};
                `REG_WAIT:   reg_rdata <= wait_q;
                `REG_STATUS: reg_rdata <= {23'h0, rx_on, state_q, poll_status, poll_ready};
                `REG_COUNT:  reg_rdata <= {16'h0, poll_cnt_q};
                default:     reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end
end

endmodule // mac_poll_sequencer

/* File: sim/mac_poll_sequencer_sva.sv */
// port assertions for the poll sequencer
`timescale 1ns/1ps
`include "poll_seq_regs.vh"
module poll_seq_chk (
    input wire        core_clk,           // clock
    input wire        arst_n,             // reset
    input wire        poll_req,           // request
    input wire        poll_ready,         // idle
    input wire [1:0]  coord_mode,         // mode
    input wire [15:0] coord_vpan,         // vpan
    input wire [2:0]  sec_level,          // level
    input wire [1:0]  key_mode,           // key mode
    input wire [7:0]  key_index,          // key index
    input wire        poll_cfm,           // confirm
    input wire [3:0]  poll_status,        // status
    input wire        data_ind,           // indication
    input wire        sec_start,          // engine start
    input wire        sec_done,           // engine done
    input wire [1:0]  sec_err,            // engine code
    input wire        tx_cmd,             // command out
    input wire        tx_sec_en,          // security bit
    input wire        tx_chan_fail,       // access failed
    input wire        ack_timeout,        // no ack
    input wire        ack_rx,             // ack
    input wire        frame_pending_flag, // pending bit
    input wire        rx_on,              // receiver on
    input wire        rx_frame,           // frame
    input wire        rx_is_cmd,          // command frame
    input wire [6:0]  rx_len              // length
);
    // ----------------------------------------
    // request decode and properties
    // ----------------------------------------
    wire take = poll_req && poll_ready;
    // key fields only matter once security is asked for
    wire ok = coord_mode[1] && coord_vpan != 16'hFFFF
              && (sec_level == 3'h0 || key_mode == 2'h0 || key_index != 8'h00);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    a_bad_param: assert property (take && !ok |=> poll_cfm && poll_status == `ST_INVALID)
        else $error("bad request not refused");
    a_plain_send: assert property (take && ok && sec_level == 3'h0
        |=> tx_cmd && !tx_sec_en && !poll_ready)
        else $error("plain command not sent");
    a_secure_start: assert property (take && ok && sec_level != 3'h0 |=> sec_start && !tx_cmd)
        else $error("security not started");
    a_sec_drop: assert property (sec_done && sec_err != `SEC_OK
        |=> poll_cfm && !tx_cmd && poll_status == 4'h3 + $past(sec_err))
        else $error("security error not confirmed");
    a_chan_fail: assert property (tx_chan_fail |=> poll_cfm && poll_status == `ST_CHAN_FAIL)
        else $error("access failure not confirmed");
    a_no_ack: assert property (ack_timeout |=> poll_cfm && poll_status == `ST_NO_ACK)
        else $error("missing ack not confirmed");
    a_ack_empty: assert property (ack_rx && !frame_pending_flag |=> poll_cfm && poll_status == `ST_NO_DATA)
        else $error("empty ack not confirmed");
    a_rx_enable: assert property (ack_rx && frame_pending_flag |=> rx_on && !poll_cfm)
        else $error("receiver not enabled");
    a_frame_class: assert property (rx_on && rx_frame |=> poll_cfm && !rx_on
        && poll_status == (($past(rx_is_cmd) || $past(rx_len) == 7'h00) ? `ST_NO_DATA : `ST_SUCCESS))
        else $error("frame wrongly classified");
    a_cfm_order: assert property (poll_cfm && poll_status == `ST_SUCCESS |-> !data_ind ##1 data_ind)
        else $error("indication out of order");
    a_busy_recv: assert property (rx_on |-> !poll_ready)
        else $error("request open while receiving");
endmodule // poll_seq_chk

bind mac_poll_sequencer poll_seq_chk u_poll_seq_chk (.*);

/* File: sim/coord_model.sv */
// coordinator and security engine model on the far side
`timescale 1ns/1ps
module coord_model (
    input  wire       core_clk,                // clock
    input  wire       sec_start,               // engine start
    input  wire       tx_cmd,                  // command out
    input  wire       rx_on,                   // receiver on
    input  wire [2:0] pm,                      // reply kind
    input  wire [1:0] serr,                    // engine code
    input  wire       cmd,                     // reply is command
    input  wire [6:0] len,                     // reply length
    output reg        sec_done = 1'b0,         // engine done
    output reg  [1:0] sec_err = 2'h0,          // engine code
    output reg        tx_done = 1'b0,          // sent
    output reg        tx_chan_fail = 1'b0,     // access failed
    output reg        ack_rx = 1'b0,           // ack
    output reg        ack_timeout = 1'b0,      // no ack
    output reg        frame_pending_flag = 1'b0, // pending bit
    output reg        rx_frame = 1'b0,         // frame
    output reg        rx_is_cmd = 1'b0,        // command frame
    output reg  [6:0] rx_len = 7'h00           // length
);
    // ----------------------------------------
    // replies; stale qualifiers are inverted so nothing relies on them
    // ----------------------------------------
    always begin
        @(posedge core_clk);
        if (sec_start) begin
            repeat (2) @(posedge core_clk);
            sec_done <= 1'b1;
            sec_err  <= serr;
            @(posedge core_clk);
            sec_done <= 1'b0;
            sec_err  <= ~serr;
        end
    end
    // link side: kind 0 access fails, 1 no ack, 2 empty ack, 3 frame, 4 silence
    always begin
        @(posedge core_clk);
        if (tx_cmd) begin
            repeat (2) @(posedge core_clk);
            tx_chan_fail <= (pm == 3'd0);
            tx_done      <= (pm != 3'd0);
            @(posedge core_clk);
            tx_chan_fail <= 1'b0;
            tx_done      <= 1'b0;
            repeat (2) @(posedge core_clk);
            ack_timeout        <= (pm == 3'd1);
            ack_rx             <= (pm > 3'd1);
            frame_pending_flag <= (pm > 3'd2);
            @(posedge core_clk);
            ack_timeout        <= 1'b0;
            ack_rx             <= 1'b0;
            frame_pending_flag <= ~frame_pending_flag;
            repeat (3) @(posedge core_clk);
            if (pm == 3'd3 && rx_on) begin
                rx_frame  <= 1'b1;
                rx_is_cmd <= cmd;
                rx_len    <= len;
                @(posedge core_clk);
                rx_frame  <= 1'b0;
                rx_is_cmd <= ~cmd;
                rx_len    <= ~len;
            end
        end
    end
endmodule // coord_model

/* File: sim/tb_top.sv */
// self-checking bench for the poll sequencer
`timescale 1ns/1ps
`include "poll_seq_regs.vh"
module tb_top;
    reg         core_clk, arst_n = 0, poll_req = 0, optical_tick = 0, cap_active = 0, reg_wr = 0, reg_rd = 0;
    reg         cmd = 0, rd_d = 0, own = 0;
    reg  [1:0]  coord_mode = 0, key_mode = 0, serr = 0;
    reg  [2:0]  sec_level = 0, pm = 0;
    reg  [3:0]  reg_addr = 0;
    reg  [6:0]  len = 0, lr;
    reg  [7:0]  key_index = 0;
    reg  [15:0] coord_vpan = 0;
    reg  [31:0] reg_wdata = 0;
    reg  [63:0] coord_addr = 0;
    wire        poll_ready, poll_cfm, data_ind, sec_start, sec_done, tx_cmd, tx_dst_present, tx_sec_en, tx_done;
    wire        tx_chan_fail, ack_rx, ack_timeout, frame_pending_flag, rx_on, rx_frame, rx_is_cmd;
    wire [1:0]  sec_err, tx_mode;
    wire [3:0]  poll_status;
    wire [6:0]  data_len, rx_len;
    wire [15:0] tx_vpan;
    wire [31:0] reg_rdata;
    wire [63:0] tx_addr;
    logic [31:0] st_q[$], len_q[$], rd_q[$];
    integer     n_mismatch = 0, n_tests = 0, n_cfm = 0, polls = 0, cyc = 0, i;
    mac_poll_sequencer u_mac_poll_sequencer (.*);
    coord_model u_coord_model (.*);
    // ----------------------------------------
    // clocks, checks and drivers
    // ----------------------------------------
    initial begin
        core_clk = 0;
        forever #2.5 core_clk = ~core_clk;
    end
    task check(input [63:0] got, input [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task close_out;
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // watcher: pulses stand one cycle, so each is seen at exactly one edge
    always @(posedge core_clk) begin
        rd_d <= reg_rd;
        cyc  <= cyc + 1;
        if (cyc % 3 == 0) optical_tick <= ~optical_tick; // six core cycles per optical clock
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
        if (poll_cfm) n_cfm <= n_cfm + 1;
        if (poll_cfm) check(poll_status, st_q.pop_front());
        if (data_ind) check(data_len, len_q.pop_front());
        if (rd_d) check(reg_rdata, rd_q.pop_front());
        if (tx_cmd) check(tx_sec_en, sec_level != 0);
        if (tx_cmd && own) check(tx_dst_present, 0);
        if (tx_cmd && !own) check({tx_dst_present, tx_mode, tx_vpan}, {1'b1, coord_mode, coord_vpan});
        if (tx_cmd && !own) check(tx_addr, coord_addr);
    end
    task wr(input [3:0] a, input [31:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input [3:0] a, input [31:0] e);
        @(posedge core_clk);
        rd_q.push_back(e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask
    // kinds 5 and 6 spoil the vpan or the key index
    task poll(input [2:0] m, input [1:0] cm, input [2:0] sl, input [1:0] se, input c, input [6:0] l, input [3:0] st);
        integer k, n0;
        @(posedge core_clk);
        {pm, serr, cmd, len, coord_mode, sec_level} <= {m, se, c, l, cm, sl};
        key_mode   <= {1'b0, sl != 0};
        key_index  <= (m == 3'd6) ? 8'h00 : 8'h01 + 8'($urandom % 255);
        coord_vpan <= (m == 3'd5) ? 16'hFFFF : 16'($urandom % 32'hFFFF);
        coord_addr <= {$urandom, $urandom};
        poll_req   <= 1'b1;
        st_q.push_back(st);
        if (st == `ST_SUCCESS) len_q.push_back(l);
        n0 = n_cfm;
        @(posedge core_clk);
        poll_req <= (m == 3'd1); // a second request while busy is ignored
        @(posedge core_clk);
        poll_req <= 1'b0;
        for (k = 0; k < 400 && n_cfm == n0; k++) @(posedge core_clk);
        repeat (3) @(posedge core_clk);
        polls++;
    endtask
    // main sequence
    initial begin
        void'($urandom(32'h32d0));
        repeat (20) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(`REG_WAIT, `WAIT_RESET);
        rd(`REG_CTRL, 0);
        wr(`REG_WAIT, 4);
        rd(`REG_WAIT, 4);
        rd(4'hF, 0);
        lr = 7'h01 + 7'($urandom % 127);
        poll(0, 3, 0, 0, 0, 0, `ST_CHAN_FAIL);
        poll(1, 2, 0, 0, 0, 0, `ST_NO_ACK);
        poll(2, 3, 3, 0, 0, 0, `ST_NO_DATA);
        poll(3, 2, 0, 0, 0, lr, `ST_SUCCESS);
        poll(3, 3, 7, 0, 0, 0, `ST_NO_DATA);
        poll(3, 3, 0, 0, 1, 5, `ST_NO_DATA);
        poll(4, 3, 0, 0, 0, 0, `ST_NO_DATA);
        for (i = 0; i < 4; i++) poll(i == 3 ? 6 : i == 2 ? 5 : 2, i[1] ? 2'd3 : i[1:0], 1, 0, 0, 0, `ST_INVALID);
        for (i = 1; i < 4; i++) poll(2, 3, 5, i[1:0], 0, 0, 4'h3 + i[3:0]);
        wr(`REG_CTRL, 3);
        own = 1;
        // beacon mode outside the cap: no optical clock counts, the poll must still wait
        fork
            poll(4, 3, 0, 0, 0, 0, `ST_NO_DATA);
            begin
                repeat (100) @(posedge core_clk);
                rd(`REG_STATUS, {23'h0, 1'b1, 3'h4, `ST_NO_KEY, 1'b0});
                cap_active <= 1'b1;
            end
        join
        rd(`REG_COUNT, polls);
        repeat (4) @(posedge core_clk);
        close_out();
    end
endmodule // tb_top
